// *** shared/dipc_pkg.sv ***
// Package: offsets, field layouts and reset values of the identity and PLL register bank
`default_nettype none
package dipc_pkg;
    // ************************************************************
    // Register byte addresses (low 32 bits of the system map)
    // ************************************************************
    localparam logic [31:0] ADDR_SECONDARY_PLL   = 32'hFFFF_E100;
    localparam logic [31:0] ADDR_PRIMARY_ONE     = 32'hFFFF_FF70;
    localparam logic [31:0] ADDR_PRIMARY_TWO     = 32'hFFFF_FF74;
    localparam logic [31:0] ADDR_DIE_LOW         = 32'hFFFF_FF7C;
    localparam logic [31:0] ADDR_DIE_HIGH        = 32'hFFFF_FF80;
    localparam logic [31:0] ADDR_DEVICE_IDENTIFICATION       = 32'hFFFF_FF84;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [31:0] PRIMARY_ONE_RESET    = 32'h2F02_5F00;
    localparam logic [31:0] PRIMARY_TWO_RESET    = 32'h7FC0_7200;
    localparam logic [31:0] SECONDARY_RESET      = 32'h0000_0307;

    // ************************************************************
    // Writable-bit masks; zero bits are reserved and read zero
    // ************************************************************
    localparam logic [31:0] PRIMARY_ONE_WMASK    = 32'hFFBF_FFFF;
    localparam logic [31:0] PRIMARY_TWO_WMASK    = 32'hFFDF_FFFF;
    localparam logic [31:0] SECONDARY_WMASK      = 32'h0080_0F07;

    // ************************************************************
    // Identification word field positions
    // ************************************************************
    localparam int ID_COPROC_BIT   = 31;
    localparam int ID_CONFIG_LSB   = 17;
    localparam int ID_PROCESS_LSB  = 13;
    localparam int ID_IOVOLT_BIT   = 12;
    localparam int ID_PARITY_BIT   = 11;
    localparam int ID_PROGPROT_LSB = 9;
    localparam int ID_RAMECC_BIT   = 8;
    localparam int ID_REVISION_LSB = 3;
    localparam logic [2:0] ID_FAMILY_PATTERN = 3'h5;
    localparam logic [3:0] PROCESS_LAST_LEGAL = 4'h3;
    localparam logic [1:0] PROGPROT_RESERVED  = 2'h3;

    // ************************************************************
    // Die identity field positions
    // ************************************************************
    localparam int DIE_LOT_LOW_LSB  = 22;
    localparam int DIE_WAFER_LSB    = 16;
    localparam int DIE_Y_LSB        = 8;
    localparam int DIE_LOT_LOW_W    = 10;
    localparam int DIE_LOT_HIGH_W   = 14;
endpackage : dipc_pkg
`default_nettype wire

// *** shared/dipc_bus_if.sv ***
// Interface: internal register access strobes between decoder and register bank
`default_nettype none
interface dipc_bus_if;
    logic        wr_one;
    logic        wr_two;
    logic        wr_sec;
    logic        priv;
    logic [31:0] wdata;
    logic [31:0] one_q;
    logic [31:0] two_q;
    logic [31:0] sec_q;
    modport dec  (output wr_one, wr_two, wr_sec, priv, wdata, input one_q, two_q, sec_q);
    modport bank (input wr_one, wr_two, wr_sec, priv, wdata, output one_q, two_q, sec_q);
endinterface : dipc_bus_if
`default_nettype wire

// *** hdl/dipc_pll_bank.sv ***
// PLL control register bank with privilege-gated field writes
`default_nettype none
module dipc_pll_bank
(
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    dipc_bus_if.bank        bus
);
    // Masked update keeps reserved bits at zero
    function automatic logic [31:0] dipc_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [31:0] mask);
        dipc_merge = (old_v & ~mask) | (new_v & mask);
    endfunction : dipc_merge

    logic [31:0] one_reg;
    logic [31:0] two_reg;
    logic [31:0] sec_reg;

    // Primary control one; user writes dropped
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            one_reg <= dipc_pkg::PRIMARY_ONE_RESET;
        else if (bus.wr_one && bus.priv)
            one_reg <= dipc_merge(one_reg, bus.wdata, dipc_pkg::PRIMARY_ONE_WMASK);
    end

    // Primary control two
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            two_reg <= dipc_pkg::PRIMARY_TWO_RESET;
        else if (bus.wr_two && bus.priv)
            two_reg <= dipc_merge(two_reg, bus.wdata, dipc_pkg::PRIMARY_TWO_WMASK);
    end

    // Secondary control; only oscillator halving, multiplier and divider are real
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            sec_reg <= dipc_pkg::SECONDARY_RESET;
        else if (bus.wr_sec && bus.priv)
            sec_reg <= dipc_merge(sec_reg, bus.wdata, dipc_pkg::SECONDARY_WMASK);
    end

    assign bus.one_q = one_reg;
    assign bus.two_q = two_reg;
    assign bus.sec_q = sec_reg;
endmodule : dipc_pll_bank
`default_nettype wire

// *** hdl/dipc_id_word.sv ***
// Device identification word assembly from capability straps
`default_nettype none
module dipc_id_word
#(
    parameter logic        COPROC_PRESENT = 1'b1,
    parameter logic [13:0] CONFIG_NUMBER  = 14'h0001,   // Arbitrary value
    parameter logic [3:0]  PROCESS_CODE   = 4'h3,
    parameter logic        IO_FIVE_VOLT   = 1'b0,
    parameter logic        PERIPH_PARITY  = 1'b1,
    parameter logic [1:0]  PROG_PROTECT   = 2'h2,
    parameter logic        RAM_ECC        = 1'b1,
    parameter logic [4:0]  REVISION       = 5'h01       // Arbitrary value
)
(
    output logic [31:0]     id_out
);
    // Reserved encodings are forced to legal codes: process above 0011 to 0011, program protection 11 to 00
    logic [3:0] process_code;
    logic [1:0] prog_code;
    assign process_code = (PROCESS_CODE > dipc_pkg::PROCESS_LAST_LEGAL)
                          ? dipc_pkg::PROCESS_LAST_LEGAL : PROCESS_CODE;
    assign prog_code    = (PROG_PROTECT == dipc_pkg::PROGPROT_RESERVED)
                          ? 2'h0 : PROG_PROTECT;

    // Field packing
    always_comb
    begin
        id_out = 32'h0000_0000;
        id_out[dipc_pkg::ID_COPROC_BIT]                        = COPROC_PRESENT;
        id_out[dipc_pkg::ID_CONFIG_LSB +: 14]                  = CONFIG_NUMBER;
        id_out[dipc_pkg::ID_PROCESS_LSB +: 4]                  = process_code;
        id_out[dipc_pkg::ID_IOVOLT_BIT]                        = IO_FIVE_VOLT;
        id_out[dipc_pkg::ID_PARITY_BIT]                        = PERIPH_PARITY;
        id_out[dipc_pkg::ID_PROGPROT_LSB +: 2]                 = prog_code;
        id_out[dipc_pkg::ID_RAMECC_BIT]                        = RAM_ECC;
        id_out[dipc_pkg::ID_REVISION_LSB +: 5]                 = REVISION;
        id_out[2:0] = dipc_pkg::ID_FAMILY_PATTERN;
    end
endmodule : dipc_id_word
`default_nettype wire

// *** hdl/dipc_regs.sv ***
// Top: identity and PLL configuration register bank on a plain register port
//
// Implementation choice: the plain strobed port.
`default_nettype none
// Overview of operation
// - Identification bit 31 shows whether the system coprocessor is present.
// - Identification bits 30:17 hold the die configuration number.
// - Bits 16:13 give process technology; codes above 0011 are reserved.
// - Bit 12 gives I/O voltage: 0 is 3.3 V, 1 is 5 V.
// - Bit 11 reads 1 when peripherals carry parity.
// - Bits 10:9 give program memory protection: none, parity, ECC, reserved.
// - Bit 8 reads 1 when RAM error correction exists.
// - Bits 7:3 hold the device revision.
// - Bits 2:0 always read binary 101.
// - Two read-only die registers form one per-unit 64-bit value.
// - Die low: lot low 10 bits, wafer, Y, X coordinates.
// - Die high: upper 14 lot bits in 13:0, rest reserved.
// - Primary control one resets to 0x2F025F00.
// - Primary control one fields as laid out; bit 22 reads zero.
// - Primary control two resets to 0x7FC07200.
// - Primary control two fields as laid out; bit 21 reads zero.
// - Secondary control: halving bit 23, multiplier 11:8, divider 2:0 resets 111.
module dipc_regs
#(
    parameter logic [23:0] DIE_LOT      = 24'h00_0001,
    parameter logic [5:0]  DIE_WAFER    = 6'h01,
    parameter logic [7:0]  DIE_X        = 8'h01,
    parameter logic [7:0]  DIE_Y        = 8'h01,
    parameter logic [4:0]  REVISION     = 5'h01
)
(
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic [31:0] addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic        priv_in,
    output logic      [31:0] rdata_out,
    output logic      [31:0] primary_one_out,
    output logic      [31:0] primary_two_out,
    output logic      [31:0] secondary_out
);
    // ************************************************************
    // Internal wiring
    // ************************************************************
    dipc_bus_if  bus ();
    logic [31:0] id_word;
    logic [31:0] die_low;
    logic [31:0] die_high;
    logic [31:0] rdata_next;

    // ************************************************************
    // Identity sources
    // ************************************************************
    dipc_id_word #(
        .REVISION (REVISION)
    ) u_id (
        .id_out   (id_word)
    );

    // Die value is fixed per unit, so it is a constant set at build time
    assign die_low  = {DIE_LOT[dipc_pkg::DIE_LOT_LOW_W-1:0], DIE_WAFER,
                       DIE_Y, DIE_X};
    assign die_high = {18'h0_0000,
                       DIE_LOT[23:dipc_pkg::DIE_LOT_LOW_W]};

    // ************************************************************
    // Write decode; die and identity words have no write path
    // ************************************************************
    assign bus.wr_one = wr_in && (addr_in == dipc_pkg::ADDR_PRIMARY_ONE);
    assign bus.wr_two = wr_in && (addr_in == dipc_pkg::ADDR_PRIMARY_TWO);
    assign bus.wr_sec = wr_in && (addr_in == dipc_pkg::ADDR_SECONDARY_PLL);
    assign bus.priv   = priv_in;
    assign bus.wdata  = wdata_in;

    dipc_pll_bank u_bank (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .bus      (bus)
    );

    // ************************************************************
    // Read mux; unmapped addresses read zero
    // ************************************************************
    always_comb
    begin
        unique case (addr_in)
            dipc_pkg::ADDR_PRIMARY_ONE:   rdata_next = bus.one_q;
            dipc_pkg::ADDR_PRIMARY_TWO:   rdata_next = bus.two_q;
            dipc_pkg::ADDR_SECONDARY_PLL: rdata_next = bus.sec_q;
            dipc_pkg::ADDR_DIE_LOW:       rdata_next = die_low;
            dipc_pkg::ADDR_DIE_HIGH:      rdata_next = die_high;
            dipc_pkg::ADDR_DEVICE_IDENTIFICATION:     rdata_next = id_word;
            default:                      rdata_next = 32'h0000_0000;
        endcase
    end

    // Read data registered; holds only in the cycle after the strobe
    always_ff @(posedge clk_in)
    begin
        if (reset_in || !rd_in)
            rdata_out <= 32'h0000_0000;
        else
            rdata_out <= rdata_next;
    end

    // PLL settings exported from flops for the clock generator
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            primary_one_out <= dipc_pkg::PRIMARY_ONE_RESET;
            primary_two_out <= dipc_pkg::PRIMARY_TWO_RESET;
            secondary_out   <= dipc_pkg::SECONDARY_RESET;
        end
        else
        begin
            primary_one_out <= bus.one_q;
            primary_two_out <= bus.two_q;   // Modulation legality left to software
            secondary_out   <= bus.sec_q;
        end
    end
endmodule : dipc_regs
`default_nettype wire

// *** tb/dipc_regs_sva.sv ***
// Checker: port-level properties of the identity and PLL register bank
`default_nettype none
module dipc_regs_sva
(
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic        priv_in,
    input wire logic [31:0] rdata_out,
    input wire logic [31:0] primary_one_out,
    input wire logic [31:0] primary_two_out,
    input wire logic [31:0] secondary_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Properties, single clock domain
    // ************************************************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // Read slot of the identification word
    sequence id_read;
        $past(rd_in) && $past(addr_in) == dipc_pkg::ADDR_DEVICE_IDENTIFICATION;
    endsequence
    a_family_bits: assert property (id_read |->
        rdata_out[2:0] == dipc_pkg::ID_FAMILY_PATTERN)
        else $error("family pattern wrong");
    a_codes_legal: assert property (id_read |->
        rdata_out[16:13] <= dipc_pkg::PROCESS_LAST_LEGAL &&
        rdata_out[10:9] != dipc_pkg::PROGPROT_RESERVED)
        else $error("reserved code in identification word");
    a_die_high_resv: assert property (
        $past(rd_in) && $past(addr_in) == dipc_pkg::ADDR_DIE_HIGH |->
        rdata_out[31:14] == 18'h0_0000)
        else $error("die high reserved bits set");
    a_one_resv_zero: assert property (primary_one_out[22] == 1'b0)
        else $error("control one bit 22 set");
    a_two_resv_zero: assert property (primary_two_out[21] == 1'b0)
        else $error("control two bit 21 set");
    a_sec_resv_zero: assert property (
        (secondary_out & ~dipc_pkg::SECONDARY_WMASK) == 32'h0000_0000)
        else $error("secondary reserved bits set");
    a_reset_values: assert property ($past(reset_in) |->
        primary_one_out == dipc_pkg::PRIMARY_ONE_RESET &&
        primary_two_out == dipc_pkg::PRIMARY_TWO_RESET &&
        secondary_out == dipc_pkg::SECONDARY_RESET)
        else $error("control registers not at defaults after reset");
    a_user_write_ignored: assert property (wr_in && !priv_in ##1 !wr_in |=>
        $stable(primary_one_out) && $stable(primary_two_out) && $stable(secondary_out))
        else $error("user write changed a control register");
    a_priv_write_lands: assert property (
        wr_in && priv_in && addr_in == dipc_pkg::ADDR_PRIMARY_ONE |-> ##2
        primary_one_out == ($past(wdata_in, 2) & dipc_pkg::PRIMARY_ONE_WMASK))
        else $error("privileged write to control one lost");
    a_read_matches_reg: assert property (
        $past(rd_in) && $past(addr_in) == dipc_pkg::ADDR_PRIMARY_TWO |->
        rdata_out == primary_two_out)
        else $error("control two read differs from register");
    // Main scenarios reached
    c_priv_write: cover property (wr_in && priv_in);
    c_user_write: cover property (wr_in && !priv_in);
    c_id_read: cover property (id_read);
endmodule : dipc_regs_sva
bind dipc_regs dipc_regs_sva dipc_regs_sva_i
(
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .priv_in(priv_in), .rdata_out(rdata_out),
    .primary_one_out(primary_one_out), .primary_two_out(primary_two_out),
    .secondary_out(secondary_out)
);
`default_nettype wire

// *** tb/tb_dipc_regs.sv ***
// Testbench: identity and PLL register bank driven over its register port
`default_nettype none
module tb_dipc_regs;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Stimulus, expectations and checking
    // ************************************************************
    localparam logic [23:0] LOT = 24'hA5C3E1;
    localparam logic [5:0]  WAF = 6'h2B;
    localparam logic [7:0]  DX  = 8'h4D;
    localparam logic [7:0]  DY  = 8'hB2;
    localparam logic [4:0]  REV = 5'h16;
    logic        clk_in = 1'b0, reset_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, priv_in = 1'b0;
    logic        pend = 1'b0;
    logic [31:0] addr_in = 32'h0, wdata_in = 32'h0, exp_v = 32'h0, pend_exp = 32'h0;
    logic [31:0] rdata_out, one_out, two_out, sec_out, seed = 32'hA3A73A2F;
    logic [31:0] sh [3];
    logic [31:0] adr [3] = '{dipc_pkg::ADDR_PRIMARY_ONE, dipc_pkg::ADDR_PRIMARY_TWO,
                             dipc_pkg::ADDR_SECONDARY_PLL};
    logic [31:0] msk [3] = '{dipc_pkg::PRIMARY_ONE_WMASK, dipc_pkg::PRIMARY_TWO_WMASK,
                             dipc_pkg::SECONDARY_WMASK};
    int          fails = 0, compares = 0, cyc = 0;

    dipc_regs #(.DIE_LOT(LOT), .DIE_WAFER(WAF), .DIE_X(DX), .DIE_Y(DY), .REVISION(REV)) dipc_regs_i
    (
        .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .priv_in(priv_in), .rdata_out(rdata_out),
        .primary_one_out(one_out), .primary_two_out(two_out), .secondary_out(sec_out)
    );

    // Free-running 20 MHz clock
    initial forever #25 clk_in = ~clk_in;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // Identification word expected from the strap defaults of the identity source
    function automatic logic [31:0] id_expect(input logic [4:0] rev);
        return {1'b1, 14'h0001, 4'h3, 1'b0, 1'b1, 2'h2, 1'b1, rev,
                dipc_pkg::ID_FAMILY_PATTERN};
    endfunction : id_expect

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // Strobes are only raised here and in rd; idle lowers them, so none is set twice in a step
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic p);
        addr_in <= a;
        wdata_in <= d;
        priv_in <= p;
        wr_in <= 1'b1;
        rd_in <= 1'b0;
        for (int k = 0; k < 3; k++)
            if (p && a === adr[k])
                sh[k] = d & msk[k];
        @(posedge clk_in);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        addr_in <= a;
        exp_v <= e;
        rd_in <= 1'b1;
        wr_in <= 1'b0;
        @(posedge clk_in);
    endtask : rd

    task automatic idle();
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        @(posedge clk_in);
    endtask : idle

    // Read data are judged in the one cycle they stand; hang guard beside it
    always @(posedge clk_in)
    begin
        if (pend)
            check(rdata_out, pend_exp);
        pend <= rd_in;
        pend_exp <= exp_v;
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            report_and_stop();
        end
    end

    // Two passes: power-up reset, then a short reset in mid-run
    initial
    begin
        logic [31:0] d;
        int          k;
        for (int r = 0; r < 2; r++)
        begin
            reset_in <= 1'b1;
            repeat (r ? 2 : 12) @(posedge clk_in);
            reset_in <= 1'b0;
            sh = '{dipc_pkg::PRIMARY_ONE_RESET, dipc_pkg::PRIMARY_TWO_RESET,
                   dipc_pkg::SECONDARY_RESET};
            @(posedge clk_in);
            check(one_out, 32'h2F02_5F00);
            check(two_out, 32'h7FC0_7200);
            check(sec_out, dipc_pkg::SECONDARY_RESET);
            // Read-only and unmapped places ignore even privileged writes
            wr(dipc_pkg::ADDR_DIE_LOW, 32'h0, 1'b1);
            wr(dipc_pkg::ADDR_DEVICE_IDENTIFICATION, 32'h0, 1'b1);
            wr(32'hFFFF_FF88, 32'hFFFF_FFFF, 1'b1);
            rd(dipc_pkg::ADDR_DEVICE_IDENTIFICATION, id_expect(REV));
            rd(dipc_pkg::ADDR_DIE_LOW, {LOT[9:0], WAF, DY, DX});
            rd(dipc_pkg::ADDR_DIE_HIGH, {18'h0, LOT[23:10]});
            rd(32'hFFFF_FF88, 32'h0);
            for (int i = 0; i < 60; i++)
            begin
                seed = xs(seed);
                k = seed[9:8] % 3;
                d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : xs(seed ^ 32'h5A5A_5A5A);
                // Spread amount kept at zero while modulation is on; legal pairs are unknown
                if (k == 1 && d[31])
                    d[8:0] = 9'h000;
                wr(adr[k], d, seed[2] || i < 2);
                rd(adr[k], sh[k]);
            end
            repeat (3) idle();
            check(one_out, sh[0]);
            check(two_out, sh[1]);
            check(sec_out, sh[2]);
        end
        report_and_stop();
    end
endmodule : tb_dipc_regs
`default_nettype wire
